// [hdl/insn_decode_map.svh]
// Field positions, encodings and timing counts of the instruction decoder.
`ifndef INSN_DECODE_MAP_SVH
`define INSN_DECODE_MAP_SVH

`define WORD_W          14
`define FILE_ADDR_LSB   0
`define FILE_ADDR_MSB   6
`define DEST_BIT        7
`define BITSEL_LSB      7
`define BITSEL_MSB      9
`define LIT8_MSB        7
`define LIT11_MSB       10
`define GROUP_MSB       13
`define GROUP_LSB       12
`define GROUP_BYTE      2'h0
`define GROUP_BIT       2'h1
`define GROUP_JUMP      2'h2
`define GROUP_LIT       2'h3
`define OSC_PER_CYCLE   3'h4
`define PHASE_LAST      2'h3
`define W_RESET         8'h00

`endif

// [hdl/insn_decode_pkg.sv]
// Types shared by the instruction decoder files.
package insn_decode_pkg;

   typedef enum logic [1:0] {
      GRP_BYTE,
      GRP_BIT,
      GRP_LITCTL
   } group_t;

   typedef enum logic [4:0] {
      OP_IDLE, OP_MOVWF, OP_CLRW, OP_CLRF, OP_SUBWF, OP_DECF, OP_IORWF, OP_ANDWF,
      OP_XORWF, OP_ADDWF, OP_MOVF, OP_COMF, OP_INCF, OP_DECFSZ, OP_RRF, OP_RLF,
      OP_SWAPF, OP_INCFSZ, OP_BCF, OP_BSF, OP_BTFSC, OP_BTFSS, OP_CALL, OP_GOTO,
      OP_MOVLW, OP_RETLW, OP_IORLW, OP_ANDLW, OP_XORLW, OP_SUBLW, OP_ADDLW, OP_CTRL
   } op_t;

endpackage : insn_decode_pkg

// [hdl/insn_field_split.sv]
// Combinational split of one instruction word into group, operation and operands.
`timescale 1ns/1ps
`include "insn_decode_map.svh"

module insn_field_split (
   input  wire logic [13:0]              i_word,
   output insn_decode_pkg::group_t       o_group,
   output insn_decode_pkg::op_t          o_op,
   output logic      [6:0]               o_file_addr,
   output logic                          o_dest_file,
   output logic      [2:0]               o_bit_sel,
   output logic      [10:0]              o_literal,
   output logic                          o_lit_long,
   output logic                          o_is_skip,
   output logic                          o_is_branch
);

   logic [1:0] grp;
   logic [3:0] sub;

   always_comb begin
      grp         = i_word[`GROUP_MSB:`GROUP_LSB];
      sub         = i_word[11:8];
      o_file_addr = i_word[`FILE_ADDR_MSB:`FILE_ADDR_LSB];
      o_dest_file = i_word[`DEST_BIT];
      o_bit_sel   = i_word[`BITSEL_MSB:`BITSEL_LSB];
      o_lit_long  = (grp == `GROUP_JUMP);
      o_literal   = o_lit_long ? i_word[`LIT11_MSB:0]
                               : {3'h0, i_word[`LIT8_MSB:0]};
      o_is_skip   = 1'b0;
      o_is_branch = 1'b0;
      o_op        = insn_decode_pkg::OP_IDLE;
      o_group     = insn_decode_pkg::GRP_LITCTL;
      unique case (grp)
         `GROUP_BYTE: begin
            o_group = insn_decode_pkg::GRP_BYTE;
            unique case (sub)
               4'h0: begin
                  if (i_word[7])
                     o_op = insn_decode_pkg::OP_MOVWF;
                  else if (i_word[6:0] != 7'h00 && i_word[6:0] != 7'h20 &&
                           i_word[6:0] != 7'h40 && i_word[6:0] != 7'h60) begin
                     // Bits 6..5 are don't-care for the idle slot only.
                     o_group = insn_decode_pkg::GRP_LITCTL;
                     o_op    = insn_decode_pkg::OP_CTRL;
                     o_is_branch = (i_word[6:0] == 7'h08) || (i_word[6:0] == 7'h09);
                  end
               end
               4'h1: o_op = i_word[7] ? insn_decode_pkg::OP_CLRF : insn_decode_pkg::OP_CLRW;
               4'h2: o_op = insn_decode_pkg::OP_SUBWF;
               4'h3: o_op = insn_decode_pkg::OP_DECF;
               4'h4: o_op = insn_decode_pkg::OP_IORWF;
               4'h5: o_op = insn_decode_pkg::OP_ANDWF;
               4'h6: o_op = insn_decode_pkg::OP_XORWF;
               4'h7: o_op = insn_decode_pkg::OP_ADDWF;
               4'h8: o_op = insn_decode_pkg::OP_MOVF;
               4'h9: o_op = insn_decode_pkg::OP_COMF;
               4'ha: o_op = insn_decode_pkg::OP_INCF;
               4'hb: begin
                  o_op = insn_decode_pkg::OP_DECFSZ;
                  o_is_skip = 1'b1;
               end
               4'hc: o_op = insn_decode_pkg::OP_RRF;
               4'hd: o_op = insn_decode_pkg::OP_RLF;
               4'he: o_op = insn_decode_pkg::OP_SWAPF;
               4'hf: begin
                  o_op = insn_decode_pkg::OP_INCFSZ;
                  o_is_skip = 1'b1;
               end
            endcase
         end
         `GROUP_BIT: begin
            o_group = insn_decode_pkg::GRP_BIT;
            unique case (sub[3:2])
               2'h0: o_op = insn_decode_pkg::OP_BCF;
               2'h1: o_op = insn_decode_pkg::OP_BSF;
               2'h2: o_op = insn_decode_pkg::OP_BTFSC;
               2'h3: o_op = insn_decode_pkg::OP_BTFSS;
            endcase
            o_is_skip = sub[3];
         end
         `GROUP_JUMP: begin
            o_op = sub[3] ? insn_decode_pkg::OP_GOTO : insn_decode_pkg::OP_CALL;
            o_is_branch = 1'b1;
         end
         `GROUP_LIT: begin
            // Don't-care low bits of the sub field are ignored here.
            casez (sub)
               4'b00??: o_op = insn_decode_pkg::OP_MOVLW;
               4'b01??: begin
                  o_op = insn_decode_pkg::OP_RETLW;
                  o_is_branch = 1'b1;
               end
               4'b1000: o_op = insn_decode_pkg::OP_IORLW;
               4'b1001: o_op = insn_decode_pkg::OP_ANDLW;
               4'b1010: o_op = insn_decode_pkg::OP_XORLW;
               4'b110?: o_op = insn_decode_pkg::OP_SUBLW;
               4'b111?: o_op = insn_decode_pkg::OP_ADDLW;
               default: o_op = insn_decode_pkg::OP_CTRL;
            endcase
         end
      endcase
   end

endmodule : insn_field_split

// [hdl/risc_instruction_decoder.sv]
// Instruction decoder with cycle timing, idle slot insertion and working register.
// How it works
// - Each instruction is one 14-bit word: operation field plus operand fields.
// - Every word is classed as byte, bit, or literal/control operation.
// - Byte operations send the result to W when d is 0, else to file.
// - The register operand addresses file locations 0x00 to 0x7F.
// - Bit operations pick one of eight bits of the addressed register.
// - Literal and control words yield an eight or eleven bit literal.
// - Don't-care bits never change how a word decodes.
// - A working register serves as accumulator source and destination.
// - An instruction finishes in one cycle unless it skips or branches.
// - A taken skip or branch costs a second cycle that does nothing.
// - One instruction cycle is exactly four oscillator clock periods.
// - The register operand sits in the low seven bits of the word.
`timescale 1ns/1ps
`include "insn_decode_map.svh"

module risc_instruction_decoder (
   input  wire logic                     i_core_clk,
   input  wire logic                     i_nrst,
   input  wire logic [13:0]              i_fetch_word,
   input  wire logic                     i_skip_true,
   input  wire logic                     i_w_load,
   input  wire logic [7:0]               i_w_data,
   output logic                          o_cycle_strobe,
   output logic      [1:0]               o_phase,
   output logic                          o_idle_slot,
   output logic                          o_flush,
   output insn_decode_pkg::group_t       o_group,
   output insn_decode_pkg::op_t          o_op,
   output logic      [6:0]               o_file_addr,
   output logic                          o_dest_file,
   output logic                          o_write_w,
   output logic      [2:0]               o_bit_sel,
   output logic      [10:0]              o_literal,
   output logic                          o_lit_long,
   output logic      [7:0]               o_w_value
);

   // ----------------------------------------------------------------
   // Phase counter
   // ----------------------------------------------------------------
   logic [1:0] phase_reg;
   logic [1:0] phase_next;

   always_comb begin
      phase_next = phase_reg + 2'h1;
   end

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst)
         phase_reg <= 2'h0;
      else
         phase_reg <= phase_next;
   end

   logic cyc_end;
   assign cyc_end        = (phase_reg == `PHASE_LAST);
   assign o_cycle_strobe = cyc_end;
   assign o_phase        = phase_reg;

   // ----------------------------------------------------------------
   // Field split of the fetched word
   // ----------------------------------------------------------------
   insn_decode_pkg::group_t s_group;
   insn_decode_pkg::op_t    s_op;
   logic [6:0]              s_file;
   logic                    s_dest;
   logic [2:0]              s_bit;
   logic [10:0]             s_lit;
   logic                    s_long;
   logic                    s_skip;
   logic                    s_branch;

   insn_field_split u_split (
      .i_word      (i_fetch_word),
      .o_group     (s_group),
      .o_op        (s_op),
      .o_file_addr (s_file),
      .o_dest_file (s_dest),
      .o_bit_sel   (s_bit),
      .o_literal   (s_lit),
      .o_lit_long  (s_long),
      .o_is_skip   (s_skip),
      .o_is_branch (s_branch)
   );

   // ----------------------------------------------------------------
   // Instruction register and idle slot control
   // ----------------------------------------------------------------
   insn_decode_pkg::group_t group_reg, group_next;
   insn_decode_pkg::op_t    op_reg, op_next;
   logic [6:0]              file_reg, file_next;
   logic                    dest_reg, dest_next;
   logic [2:0]              bit_reg, bit_next;
   logic [10:0]             lit_reg, lit_next;
   logic                    long_reg, long_next;
   logic                    skip_reg, skip_next;
   logic                    branch_reg, branch_next;
   logic                    idle_reg, idle_next;
   logic                    flush;

   // The current instruction resolves at the end of its cycle; a taken
   // skip or any branch discards the word already fetched behind it.
   assign flush = cyc_end && !idle_reg && (branch_reg || (skip_reg && i_skip_true));

   always_comb begin
      group_next  = group_reg;
      op_next     = op_reg;
      file_next   = file_reg;
      dest_next   = dest_reg;
      bit_next    = bit_reg;
      lit_next    = lit_reg;
      long_next   = long_reg;
      skip_next   = skip_reg;
      branch_next = branch_reg;
      idle_next   = idle_reg;
      if (cyc_end) begin
         if (flush) begin
            group_next  = insn_decode_pkg::GRP_BYTE;
            op_next     = insn_decode_pkg::OP_IDLE;
            file_next   = 7'h00;
            dest_next   = 1'b0;
            bit_next    = 3'h0;
            lit_next    = 11'h000;
            long_next   = 1'b0;
            skip_next   = 1'b0;
            branch_next = 1'b0;
            idle_next   = 1'b1;
         end else begin
            group_next  = s_group;
            op_next     = s_op;
            file_next   = s_file;
            dest_next   = s_dest;
            bit_next    = s_bit;
            lit_next    = s_lit;
            long_next   = s_long;
            skip_next   = s_skip;
            branch_next = s_branch;
            idle_next   = 1'b0;
         end
      end
   end

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         group_reg  <= insn_decode_pkg::GRP_BYTE;
         op_reg     <= insn_decode_pkg::OP_IDLE;
         file_reg   <= 7'h00;
         dest_reg   <= 1'b0;
         bit_reg    <= 3'h0;
         lit_reg    <= 11'h000;
         long_reg   <= 1'b0;
         skip_reg   <= 1'b0;
         branch_reg <= 1'b0;
         idle_reg   <= 1'b1;
      end else begin
         group_reg  <= group_next;
         op_reg     <= op_next;
         file_reg   <= file_next;
         dest_reg   <= dest_next;
         bit_reg    <= bit_next;
         lit_reg    <= lit_next;
         long_reg   <= long_next;
         skip_reg   <= skip_next;
         branch_reg <= branch_next;
         idle_reg   <= idle_next;
      end
   end

   // ----------------------------------------------------------------
   // Result steering
   // ----------------------------------------------------------------
   logic write_w;

   always_comb begin
      write_w = 1'b0;
      if (!idle_reg) begin
         unique case (group_reg)
            insn_decode_pkg::GRP_BYTE:   write_w = !dest_reg && (op_reg != insn_decode_pkg::OP_IDLE) &&
                                                   (op_reg != insn_decode_pkg::OP_MOVWF);
            insn_decode_pkg::GRP_BIT:    write_w = 1'b0;
            insn_decode_pkg::GRP_LITCTL: write_w = !long_reg && (op_reg != insn_decode_pkg::OP_CTRL);
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Working register
   // ----------------------------------------------------------------
   logic [7:0] w_reg;
   logic [7:0] w_next;

   always_comb begin
      w_next = w_reg;
      if (i_w_load)
         w_next = i_w_data;
   end

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst)
         w_reg <= `W_RESET;
      else
         w_reg <= w_next;
   end

   assign o_idle_slot = idle_reg;
   assign o_flush     = flush;
   assign o_group     = group_reg;
   assign o_op        = op_reg;
   assign o_file_addr = file_reg;
   assign o_dest_file = dest_reg;
   assign o_write_w   = write_w;
   assign o_bit_sel   = bit_reg;
   assign o_literal   = lit_reg;
   assign o_lit_long  = long_reg;
   assign o_w_value   = w_reg;

endmodule : risc_instruction_decoder

// [sim/decoder_checker.sv]
// Concurrent checks on the decoder ports.
`timescale 1ns/1ps

module decoder_checker (
   input wire logic                    i_core_clk,
   input wire logic                    i_nrst,
   input wire logic [13:0]             i_fetch_word,
   input wire logic                    i_skip_true,
   input wire logic                    i_w_load,
   input wire logic [7:0]              i_w_data,
   input wire logic                    o_cycle_strobe,
   input wire logic [1:0]              o_phase,
   input wire logic                    o_idle_slot,
   input wire logic                    o_flush,
   input wire insn_decode_pkg::group_t o_group,
   input wire insn_decode_pkg::op_t    o_op,
   input wire logic [6:0]              o_file_addr,
   input wire logic                    o_dest_file,
   input wire logic                    o_write_w,
   input wire logic [2:0]              o_bit_sel,
   input wire logic [10:0]             o_literal,
   input wire logic                    o_lit_long,
   input wire logic [7:0]              o_w_value
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);

   a_phase_four_cycle: assert property (o_phase == 2'h0 |=> o_phase == 2'h1 ##1 o_phase == 2'h2
      ##1 o_phase == 2'h3 ##1 o_phase == 2'h0) else $error("phase sequence broken");
   a_strobe_phase: assert property (o_cycle_strobe == (o_phase == 2'h3))
      else $error("strobe not in last phase");
   a_decode_stands: assert property (o_phase != 2'h3 |=> $stable(o_op) && $stable(o_literal)
      && $stable(o_file_addr)) else $error("decode changed mid cycle");
   a_flush_idle_next: assert property (o_flush |=> (o_idle_slot && o_op == insn_decode_pkg::OP_IDLE)[*4])
      else $error("no idle slot after flush");
   a_flush_in_phase: assert property (o_flush |-> o_phase == 2'h3) else $error("flush outside phase 3");
   a_skip_taken: assert property (o_phase == 2'h3 && !o_idle_slot && o_op == insn_decode_pkg::OP_DECFSZ
      && i_skip_true |-> o_flush) else $error("taken skip did not flush");
   a_plain_no_flush: assert property (o_op inside {[insn_decode_pkg::OP_MOVWF:insn_decode_pkg::OP_DECF]}
      |-> !o_flush) else $error("plain op flushed");
   a_w_load_value: assert property (i_w_load |=> o_w_value == $past(i_w_data))
      else $error("W not loaded");
   a_dest_steer: assert property (o_op inside {[insn_decode_pkg::OP_SUBWF:insn_decode_pkg::OP_INCFSZ]}
      |-> o_write_w == !o_dest_file) else $error("result steering wrong");
   a_lit_width: assert property (o_group == insn_decode_pkg::GRP_LITCTL |->
      o_lit_long == (o_op inside {insn_decode_pkg::OP_CALL, insn_decode_pkg::OP_GOTO})
      && (o_lit_long || o_literal[10:8] == 3'h0)) else $error("literal width wrong");

   c_skip_flush: cover property (o_flush && o_op == insn_decode_pkg::OP_DECFSZ);
   c_goto_flush: cover property (o_flush && o_op == insn_decode_pkg::OP_GOTO);
   c_w_load: cover property (i_w_load ##1 o_w_value != 8'h00);
endmodule : decoder_checker

// [sim/prog_mem_model.sv]
// Program memory model that streams instruction words to the decoder.
`timescale 1ns/1ps

module prog_mem_model (
   input  wire logic        i_core_clk,
   input  wire logic        i_nrst,
   input  wire logic [1:0]  i_phase,
   output logic      [13:0] o_word
);
   logic [13:0] mem [0:63];
   logic [5:0]  pc_reg;
   logic [5:0]  pc_next;

   always_comb begin
      pc_next = (i_phase == 2'h3) ? pc_reg + 6'h01 : pc_reg;
   end

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         pc_reg <= 6'h00;
      end else begin
         pc_reg <= pc_next;
      end
   end

   // Outside the sampling phase the word is inverted, so a decoder that
   // latches at the wrong edge sees garbage instead of a lucky match.
   always_comb begin
      o_word = (i_phase == 2'h3) ? mem[pc_reg] : ~mem[pc_reg];
   end
endmodule : prog_mem_model

// [sim/tb_risc_instruction_decoder.sv]
// Self-checking bench for the decoder with a streaming program memory.
`timescale 1ns/1ps
`include "insn_decode_map.svh"

module tb_risc_instruction_decoder;
   logic                    clk, nrst, skip_true, w_load, cyc_strobe, idle_slot, flush;
   logic                    dest_file, write_w, lit_long, idle_exp, fl_exp;
   logic [13:0]             fetch_word, cur;
   logic [7:0]              w_data, w_value, w_exp;
   logic [1:0]              phase;
   logic [6:0]              file_addr;
   logic [2:0]              bit_sel;
   logic [10:0]             literal;
   logic [5:0]              ptr;
   insn_decode_pkg::group_t grp;
   insn_decode_pkg::op_t    op;
   int                      bad_count, compares;
   logic [13:0]             corner [0:11] = '{14'h0000, 14'h0060, 14'h0100, 14'h017f, 14'h2805, 14'h0b85,
                                              14'h3e12, 14'h3fff, 14'h2000, 14'h07ff, 14'h0008, 14'h1fff};

   prog_mem_model i_mem (.i_core_clk(clk), .i_nrst(nrst), .i_phase(phase), .o_word(fetch_word));

   risc_instruction_decoder i_dut (.i_core_clk(clk), .i_nrst(nrst), .i_fetch_word(fetch_word),
      .i_skip_true(skip_true), .i_w_load(w_load), .i_w_data(w_data), .o_cycle_strobe(cyc_strobe),
      .o_phase(phase), .o_idle_slot(idle_slot), .o_flush(flush), .o_group(grp), .o_op(op),
      .o_file_addr(file_addr), .o_dest_file(dest_file), .o_write_w(write_w), .o_bit_sel(bit_sel),
      .o_literal(literal), .o_lit_long(lit_long), .o_w_value(w_value));

   task automatic chk(input logic ok, input string msg);
      compares++;
      // An unknown result must count as a mismatch, not slip through.
      if (ok !== 1'b1) begin
         bad_count++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask : chk

   task automatic print_verdict();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : print_verdict

   function automatic insn_decode_pkg::op_t exp_op(input logic [13:0] w);
      if (w[13:12] == 2'h0 && w[11:8] == 4'h0) return w[7] ? insn_decode_pkg::OP_MOVWF : insn_decode_pkg::OP_IDLE;
      if (w[13:12] == 2'h0 && w[11:8] == 4'h1) return w[7] ? insn_decode_pkg::OP_CLRF : insn_decode_pkg::OP_CLRW;
      if (w[13:12] == 2'h0) return insn_decode_pkg::op_t'(5'(w[11:8]) + 5'h02);
      if (w[13:12] == 2'h1) return insn_decode_pkg::op_t'(5'h12 + 5'(w[11:10]));
      if (w[13:12] == 2'h2) return w[11] ? insn_decode_pkg::OP_GOTO : insn_decode_pkg::OP_CALL;
      casez (w[11:8])
         4'b00??: return insn_decode_pkg::OP_MOVLW;
         4'b01??: return insn_decode_pkg::OP_RETLW;
         4'h8:    return insn_decode_pkg::OP_IORLW;
         4'h9:    return insn_decode_pkg::OP_ANDLW;
         4'ha:    return insn_decode_pkg::OP_XORLW;
         4'hb:    return insn_decode_pkg::OP_CTRL;
         4'b110?: return insn_decode_pkg::OP_SUBLW;
         default: return insn_decode_pkg::OP_ADDLW;
      endcase
   endfunction : exp_op

   function automatic logic flushes(input logic [13:0] w, input logic sk);
      return w[13:12] == 2'h2 || w[13:10] == 4'hd || w == 14'h0008 || w == 14'h0009
         || (sk && (w[13:8] == 6'h0b || w[13:8] == 6'h0f || w[13:11] == 3'h3));
   endfunction : flushes

   task automatic check_decode(input logic [13:0] w);
      logic amb;
      amb = (w[13:7] == 7'h00) && (w[4:0] != 5'h00);
      chk(idle_slot === 1'b0, "unexpected idle slot");
      chk(grp === ((amb || w[13]) ? insn_decode_pkg::GRP_LITCTL
                                  : insn_decode_pkg::group_t'({1'b0, w[12]})), "group");
      chk(op === (amb ? insn_decode_pkg::OP_CTRL : exp_op(w)), "operation");
      if (!w[13]) chk(file_addr === w[6:0], "file address");
      if (w[13:12] != 2'h0 || w[11:8] == 4'h0)
         chk(write_w === (w[13:12] == 2'h3 && exp_op(w) != insn_decode_pkg::OP_CTRL), "W write");
      if (w[13:12] == 2'h0 && w[11:8] != 4'h0) chk(dest_file === w[7] && write_w === !w[7], "destination");
      if (w[13:12] == 2'h1) chk(bit_sel === w[9:7], "bit select");
      if (w[13]) chk(lit_long === !w[12] && literal === (w[12] ? {3'h0, w[7:0]} : w[10:0]), "literal");
   endtask : check_decode

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   initial begin
      #100000;
      bad_count++;
      print_verdict();
   end

   initial begin
      nrst = 1'b0;
      skip_true = 1'b0;
      w_load = 1'b0;
      w_data = 8'h00;
      w_exp = `W_RESET;
      cur = 14'h0000;
      void'($urandom(96));
      for (int i = 0; i < 64; i++) begin
         i_mem.mem[i] = (i < 12) ? corner[i] : 14'($urandom);
      end
      repeat (2) @(posedge clk);
      @(negedge clk);
      nrst = 1'b1;
      idle_exp = 1'b1;
      ptr = 6'h00;
      for (int c = 0; c < 90; c++) begin
         chk(phase === 2'h0 && cyc_strobe === 1'b0, "phase start");
         chk(w_value === w_exp, "working register");
         if (idle_exp) chk(idle_slot === 1'b1 && op === insn_decode_pkg::OP_IDLE, "idle slot");
         else check_decode(cur);
         skip_true = 1'($urandom);
         w_load = 1'($urandom);
         w_data = 8'($urandom);
         if (w_load) w_exp = w_data;
         fl_exp = !idle_exp && flushes(cur, skip_true);
         repeat (3) @(negedge clk);
         chk(cyc_strobe === 1'b1 && flush === fl_exp, "flush");
         idle_exp = fl_exp;
         cur = i_mem.mem[ptr];
         ptr++;
         @(negedge clk);
      end
      print_verdict();
   end
endmodule : tb_risc_instruction_decoder

bind risc_instruction_decoder decoder_checker i_chk (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
   .i_fetch_word(i_fetch_word), .i_skip_true(i_skip_true), .i_w_load(i_w_load), .i_w_data(i_w_data),
   .o_cycle_strobe(o_cycle_strobe), .o_phase(o_phase), .o_idle_slot(o_idle_slot), .o_flush(o_flush),
   .o_group(o_group), .o_op(o_op), .o_file_addr(o_file_addr), .o_dest_file(o_dest_file),
   .o_write_w(o_write_w), .o_bit_sel(o_bit_sel), .o_literal(o_literal), .o_lit_long(o_lit_long),
   .o_w_value(o_w_value));
